// ### core/swimc_top.sv
// interface mode control register bank with block fill and offset evaluation
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps

module swimc_top
  import swimc_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // avalon-mm slave
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // pins
  input  wire logic                  output_drive_enable_pin,
  input  wire logic                  frame_eval_pin,
  output logic      [15:0]           serial_out_oe_n,
  // connection memory fill port
  output swimc_fill_t                fill,
  // interrupt
  output logic                       irq
);

  localparam int unsigned FW = $clog2(FRAME_LEN);

  typedef struct packed {
    swimc_mode_t       mode;
    logic              master;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  irq_en;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [FW-1:0]     frame_cnt;
    logic              frame_tick;
    swimc_fill_st_t    fst;
    logic              fill_prev;
    logic [11:0]       faddr;
    logic              fframe;
    swimc_fill_t       fill;
    swimc_eval_st_t    est;
    logic              eval_prev;
    logic [DELAY_W-1:0] delay;
    logic              done;
    logic              ode_s1;
    logic              ode_s2;
    logic              fe_s1;
    logic              fe_s2;
    logic              fe_prev;
    logic [15:0]       oe_n;
    logic              irq;
  } swimc_state_t;

  // ==========================================================
  // functions

  function automatic logic [11:0] words_of(input swimc_rate_t r);
    unique case (r)
      RATE_2M: words_of = WORDS_2M;
      RATE_4M: words_of = WORDS_4M;
      RATE_8M: words_of = WORDS_8M;
      RATE_RSV: words_of = 12'h000;
    endcase
  endfunction : words_of

  // ==========================================================
  // reset release

  logic rst_meta_n;
  logic rst_sync_n;

  // two stage release keeps recovery timing clean
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // next state

  swimc_state_t s;
  swimc_state_t next_s;
  logic         bus_wr;
  logic         fill_rise;
  logic         eval_rise;
  logic         eval_fall;
  logic         fe_fall;
  logic [IRQ_W-1:0] set_bits;
  logic [IRQ_W-1:0] clr_bits;
  logic [15:0]  wmode;

  always_comb
  begin
    next_s = s;
    set_bits = '0;
    clr_bits = '0;
    wmode = s.mode;
    next_s.frame_tick = 1'b0;
    next_s.fill.we = 1'b0;

    // pin synchronisers
    next_s.ode_s1 = output_drive_enable_pin;
    next_s.ode_s2 = s.ode_s1;
    next_s.fe_s1 = frame_eval_pin;
    next_s.fe_s2 = s.fe_s1;
    next_s.fe_prev = s.fe_s2;
    fe_fall = s.fe_prev & ~s.fe_s2;

    // frame divider, fixed 8 kHz frame at every rate
    // frame pacing
    if (s.frame_cnt == FW'(FRAME_LEN - 1))
    begin
      next_s.frame_cnt = '0;
      next_s.frame_tick = 1'b1;
    end
    else
    begin
      next_s.frame_cnt = s.frame_cnt + FW'(1);
    end

    // bus: one wait cycle, then the access completes
    next_s.waitreq = ~((read | write) & s.waitreq);
    bus_wr = write & ~s.waitreq;
    if (read & s.waitreq)
    begin
      unique case (address)
        MODE_OFS:     next_s.rdata = {16'h0000, s.mode};
        CTRL_OFS:     next_s.rdata = {31'h0, s.master};
        RESULT_OFS:   next_s.rdata = {19'h0, s.done, s.delay};
        IRQ_STAT_OFS: next_s.rdata = {29'h0, s.stat};
        IRQ_EN_OFS:   next_s.rdata = {29'h0, s.irq_en};
        default:      next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr)
    begin
      unique case (address)
        MODE_OFS:
        begin
          if (byteenable[0])
            wmode[7:0] = writedata[7:0];
          if (byteenable[1])
            wmode[15:8] = writedata[15:8];
          wmode[15:MODE_USED_W] = '0;
          next_s.mode = swimc_mode_t'(wmode);
        end
        CTRL_OFS:
          if (byteenable[0])
            next_s.master = writedata[CTRL_MASTER];
        IRQ_CLR_OFS:
          if (byteenable[0])
            clr_bits = writedata[IRQ_W-1:0];
        IRQ_EN_OFS:
          if (byteenable[0])
            next_s.irq_en = writedata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // block fill sequencer
    fill_rise = s.mode.block_fill_start & ~s.fill_prev;
    next_s.fill_prev = s.mode.block_fill_start;
    unique case (s.fst)
      FILL_IDLE:
      begin
        if (fill_rise & s.master)
        begin
          next_s.fst = FILL_RUN;
          next_s.faddr = '0;
          next_s.fframe = 1'b0;
        end
        else if (fill_rise)
        begin
          next_s.mode.block_fill_start = 1'b0;
        end
      end
      FILL_RUN:
      begin
        // abort on cleared start or master
        if (~s.mode.block_fill_start | ~s.master)
        begin
          next_s.fst = FILL_IDLE;
          next_s.mode.block_fill_start = 1'b0;
          set_bits[IRQ_FILL_ABT] = 1'b1;
        end
        else
        begin
          if (s.faddr < words_of(s.mode.serial_rate_select))
          begin
            next_s.fill.we = 1'b1;
            next_s.fill.addr = s.faddr[FILL_LOW_W-1:0];
            next_s.fill.data = {s.mode.block_fill_value, 11'h000};
            next_s.faddr = s.faddr + 12'h001;
          end
          if (s.frame_tick)
          begin
            next_s.fframe = 1'b1;
            if (s.fframe)
            begin
              next_s.fst = FILL_IDLE;
              next_s.mode.block_fill_start = 1'b0;
              set_bits[IRQ_FILL_END] = 1'b1;
            end
          end
        end
      end
    endcase

    // offset evaluation, measured in clocks after a frame boundary
    eval_rise = s.mode.offset_eval_start & ~s.eval_prev;
    eval_fall = ~s.mode.offset_eval_start & s.eval_prev;
    next_s.eval_prev = s.mode.offset_eval_start;
    if (eval_fall)
    begin
      next_s.est = EVAL_IDLE;
      next_s.done = 1'b0;
      next_s.delay = '0;
    end
    else
    begin
      unique case (s.est)
        EVAL_IDLE:
          if (eval_rise)
            next_s.est = EVAL_ARM;
        EVAL_ARM:
          if (s.frame_tick)
          begin
            next_s.est = EVAL_MEAS;
            next_s.delay = '0;
          end
        EVAL_MEAS:
          if (fe_fall)
          begin
            next_s.est = EVAL_DONE;
            next_s.done = 1'b1;
            set_bits[IRQ_EVAL_END] = 1'b1;
          end
          else if (~&s.delay)
          begin
            next_s.delay = s.delay + DELAY_W'(1);
          end
        EVAL_DONE: ;
      endcase
    end

    // sticky status, a new event wins over a clear
    next_s.stat = (s.stat & ~clr_bits) | set_bits;
    next_s.irq = |(next_s.stat & next_s.irq_en);

    // standby gating of the serial drivers
    next_s.oe_n = {16{~(s.ode_s2 | s.mode.output_standby_release)}};
  end

  // ==========================================================
  // state register

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s <= '0;
      s.mode <= swimc_mode_t'(MODE_RESET);
      s.waitreq <= 1'b1;
      s.oe_n <= 16'hFFFF;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign readdata = s.rdata;
  assign waitrequest = s.waitreq;
  assign serial_out_oe_n = s.oe_n;
  assign fill = s.fill;
  assign irq = s.irq;

  // ==========================================================
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  fill_start_a: assert property (
    s.fst == FILL_IDLE ##1 s.fst == FILL_RUN |-> $past(s.master))
    else $error("block fill began without master enable");
  fill_word_a: assert property (
    s.fill.we |-> s.fill.data[10:0] == 11'h000
      && s.fill.data[15:11] == s.mode.block_fill_value)
    else $error("fill word has wrong layout");
  fill_end_a: assert property (
    $past(s.fst) == FILL_RUN && s.fst == FILL_IDLE
      |-> !s.mode.block_fill_start)
    else $error("start bit not cleared when fill ended");
  fill_abort_a: assert property (
    s.fst == FILL_RUN && !s.master |=> s.fst == FILL_IDLE
      && s.stat[IRQ_FILL_ABT])
    else $error("fill not aborted on master clear");
  standby_a: assert property (
    !s.ode_s2 && !s.mode.output_standby_release
      |=> serial_out_oe_n == 16'hFFFF)
    else $error("outputs driven in standby");
  eval_arm_a: assert property (
    s.est == EVAL_IDLE && s.mode.offset_eval_start && !s.eval_prev
      |=> s.est == EVAL_ARM)
    else $error("evaluation did not start");
  eval_stop_a: assert property (
    $rose(s.done) |-> s.est == EVAL_DONE ##1 $stable(s.delay))
    else $error("evaluation kept running after done");
  eval_clear_a: assert property (
    $fell(s.mode.offset_eval_start) |=> !s.done && s.delay == '0)
    else $error("result not cleared on falling start");
  rate_rsv_a: assert property (
    s.mode.serial_rate_select == RATE_RSV |-> !s.fill.we || $past(s.fill.we))
    else $error("reserved rate began a fill");
  frame_a: assert property (
    s.frame_tick |-> $past(s.frame_cnt) == FW'(FRAME_LEN - 1))
    else $error("frame tick off the frame boundary");
  irq_level_a: assert property (
    irq == |(s.stat & s.irq_en))
    else $error("interrupt level mismatch");

  fill_done_c: cover property (s.stat[IRQ_FILL_END]);
  fill_abort_c: cover property (s.stat[IRQ_FILL_ABT]);
  eval_done_c: cover property ($rose(s.done));
  bus_read_c: cover property (read && !waitrequest);

endmodule : swimc_top

// ### core/swimc_pkg.sv
// constants, types and register map of the interface mode control block
package swimc_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned FRAME_US     = 125;
  localparam int unsigned FRAME_CYCLES = FRAME_US * CLK_MHZ;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] MODE_OFS     = 8'h00;
  localparam logic [7:0] CTRL_OFS     = 8'h04;
  localparam logic [7:0] RESULT_OFS   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned   MODE_USED_W  = 10;
  localparam logic [15:0]   MODE_RESET   = 16'h0000;
  localparam int unsigned   CTRL_MASTER  = 0;
  localparam int unsigned   RESULT_DONE  = 12;
  localparam int unsigned   DELAY_W      = 12;
  localparam int unsigned   IRQ_FILL_END = 0;
  localparam int unsigned   IRQ_FILL_ABT = 1;
  localparam int unsigned   IRQ_EVAL_END = 2;
  localparam int unsigned   IRQ_W        = 3;
  localparam int unsigned   FILL_LOW_W   = 11;
  localparam logic [11:0]   WORDS_2M     = 12'h200;
  localparam logic [11:0]   WORDS_4M     = 12'h400;
  localparam logic [11:0]   WORDS_8M     = 12'h800;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    RATE_2M  = 2'b00,
    RATE_4M  = 2'b01,
    RATE_8M  = 2'b10,
    RATE_RSV = 2'b11
  } swimc_rate_t;

  typedef struct packed {
    logic [5:0]  zero;
    logic [4:0]  block_fill_value;
    logic        block_fill_start;
    logic        output_standby_release;
    logic        offset_eval_start;
    swimc_rate_t serial_rate_select;
  } swimc_mode_t;

  typedef enum logic {
    FILL_IDLE = 1'b0,
    FILL_RUN  = 1'b1
  } swimc_fill_st_t;

  typedef enum logic [1:0] {
    EVAL_IDLE = 2'b00,
    EVAL_ARM  = 2'b01,
    EVAL_MEAS = 2'b10,
    EVAL_DONE = 2'b11
  } swimc_eval_st_t;

  typedef struct packed {
    logic        we;
    logic [10:0] addr;
    logic [15:0] data;
  } swimc_fill_t;

endpackage : swimc_pkg

// ### tb/swimc_cmem_model.sv
// connection memory tally and frame pulse source facing the block
`timescale 1ns/1ps

module swimc_cmem_model
  import swimc_pkg::*;
#(
  parameter int unsigned FRAME_LEN = 64
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // fill port and its tally
  input  wire swimc_fill_t fill,
  input  wire logic        clr,
  output logic [11:0]      words,
  output logic [15:0]      fill_data,
  output logic             addr_bad,
  // frame pulse pin, idle high
  output logic             frame_eval_pin
);
  logic [15:0] cnt;

  // ==========================================================
  // memory side
  // keep last word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {words, fill_data, addr_bad} <= '0;
    else if (clr)
      {words, fill_data, addr_bad} <= '0;
    else if (fill.we)
    begin
      words     <= words + 12'h001;
      fill_data <= fill.data;
      // addresses must run 0,1,2.. with no gap
      addr_bad  <= addr_bad | (fill.addr != words[10:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt            <= 16'h0000;
      frame_eval_pin <= 1'b1;
    end
    else
    begin
      cnt            <= (cnt == 16'(FRAME_LEN - 1)) ? 16'h0000 : cnt + 16'h0001;
      frame_eval_pin <= (cnt != 16'h0000);
    end
  end
endmodule : swimc_cmem_model

// ### tb/testbench.sv
// self-checking bench for the interface mode control block
`timescale 1ns/1ps

module testbench;
  import swimc_pkg::*;
  // ==========================================================
  // signals
  localparam int unsigned FL = 2100; // frame must hold 2048 fill words
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ode_pin = 1'b0;
  logic        frame_eval_pin;
  logic [15:0] serial_out_oe_n;
  swimc_fill_t fill;
  logic        irq;
  logic        clr = 1'b0;
  logic [11:0] words;
  logic [15:0] fill_data;
  logic        addr_bad;
  logic [31:0] q;
  logic [31:0] m;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #4 clk = ~clk;

  swimc_top #(.FRAME_LEN(FL)) dut_u (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
    .waitrequest(waitrequest), .output_drive_enable_pin(ode_pin),
    .frame_eval_pin(frame_eval_pin), .serial_out_oe_n(serial_out_oe_n),
    .fill(fill), .irq(irq));

  swimc_cmem_model #(.FRAME_LEN(FL)) mem_u (
    .clk(clk), .rst_n(rst_n), .fill(fill), .clr(clr), .words(words),
    .fill_data(fill_data), .addr_bad(addr_bad), .frame_eval_pin(frame_eval_pin));

  // ==========================================================
  // tasks
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= ~w;
    write     <= w;
    @(posedge clk iff waitrequest === 1'b0);
    q = readdata;
    read      <= 1'b0;
    write     <= 1'b0;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  // bounded poll; the caller compares q afterwards
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int i = 0;
    do
    begin
      bus(1'b0, a, 32'h0);
      i++;
    end
    while (q[b] !== v && i < 2000);
  endtask : poll

  // sample off the launching edge so registered outputs have settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : idle

  task automatic clr_mem;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clr_mem

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // hang guard, a few times the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================================
  // tests
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(MODE_OFS, 32'h0);
    rd(RESULT_OFS, 32'h0);
    rd(8'h40, 32'h0);
    chk({16'h0, serial_out_oe_n}, 32'hFFFF);
    $display("test reset done");
    // standby bit, then drive pin
    wr(MODE_OFS, 32'h8);
    idle(5);
    chk({16'h0, serial_out_oe_n}, 32'h0);
    wr(MODE_OFS, 32'h0);
    idle(5);
    chk({16'h0, serial_out_oe_n}, 32'hFFFF);
    @(posedge clk);
    ode_pin <= 1'b1;
    idle(5);
    chk({16'h0, serial_out_oe_n}, 32'h0);
    @(posedge clk);
    ode_pin <= 1'b0;
    $display("test standby done");
    // block fill at every rate code, reserved one fills nothing
    wr(CTRL_OFS, 32'h1);
    wr(IRQ_EN_OFS, 32'h7);
    for (int r = 0; r < 4; r++)
    begin
      clr_mem();
      m = {22'h0, 5'(r + 9), 1'b1, 4'(r)};
      wr(MODE_OFS, m);
      poll(MODE_OFS, 4, 1'b0);
      chk(q, m & ~32'h10);
      chk({20'h0, words}, (r == 3) ? 32'h0 : 32'(512 << r));
      chk({16'h0, fill_data}, (r == 3) ? 32'h0 : {16'h0, 5'(r + 9), 11'h0});
      chk({31'h0, addr_bad}, 32'h0);
      rd(IRQ_STAT_OFS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(IRQ_CLR_OFS, 32'h7);
      idle(2);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test fill done");
    // start without master enable is dropped
    wr(CTRL_OFS, 32'h0);
    clr_mem();
    wr(MODE_OFS, 32'h30);
    idle(4);
    rd(MODE_OFS, 32'h20);
    chk({20'h0, words}, 32'h0);
    // abort by start bit, then by master bit with irq masked
    for (int k = 0; k < 2; k++)
    begin
      wr(IRQ_EN_OFS, (k == 0) ? 32'h7 : 32'h0);
      wr(CTRL_OFS, 32'h1);
      clr_mem();
      wr(MODE_OFS, 32'h32);
      idle(20);
      if (k == 0)
        wr(MODE_OFS, 32'h22);
      else
        wr(CTRL_OFS, 32'h0);
      idle(3);
      rd(IRQ_STAT_OFS, 32'h2);
      chk({31'h0, irq}, (k == 0) ? 32'h1 : 32'h0);
      chk({31'h0, words > 12'h040}, 32'h0);
      wr(IRQ_CLR_OFS, 32'h7);
      wr(MODE_OFS, 32'h0);
    end
    $display("test abort done");
    // two evaluations with a full idle frame between them
    for (int e = 0; e < 2; e++)
    begin
      wr(MODE_OFS, 32'h4);
      poll(RESULT_OFS, 12, 1'b1);
      chk({31'h0, q[12]}, 32'h1);
      m = q;
      idle(50);
      rd(RESULT_OFS, m);
      rd(IRQ_STAT_OFS, 32'h4);
      wr(IRQ_CLR_OFS, 32'h7);
      wr(MODE_OFS, 32'h0);
      idle(3);
      rd(RESULT_OFS, 32'h0);
      idle(FL);
    end
    $display("test eval done");
    wrap_up();
  end
endmodule : testbench
